// >>> rtl/adc_serial_config_port.v
`timescale 1ns/1ps
`include "adc_serial_config_port_regs.vh"
module adc_serial_config_port #(
   parameter NREG = `REG_COUNT
) (
   input  wire       i_sys_clk,
   input  wire       i_rstn,
   input  wire       i_sclk,
   input  wire       i_chip_select_n,
   input  wire       i_serial_data_in,
   input  wire       i_hw_reset,
   output wire       o_serial_data_out,
   output wire       o_serial_data_out_en,
   output wire       o_write_locked,
   output wire [7:0] o_dither_disable_ctrl,
   output wire [7:0] o_lane_bit_order_ctrl,
   output wire [7:0] o_lane_swap_ctrl,
   output wire [7:0] o_lane_count_select,
   output wire [7:0] o_soft_reset_test_enable,
   output wire [7:0] o_overrange_on_lsb_ctrl,
   output wire [7:0] o_output_format_ctrl,
   output wire [7:0] o_chan_a_test_pattern_sel,
   output wire [7:0] o_chan_b_test_pattern_sel,
   output wire [7:0] o_custom_pattern_high,
   output wire [7:0] o_custom_pattern_low,
   output wire [7:0] o_low_speed_ctrl,
   output wire [7:0] o_power_down_ctrl,
   output wire [7:0] o_output_swing_ctrl,
   output wire [7:0] o_clock_divider_ctrl,
   output wire [7:0] o_high_if_a_ctrl,
   output wire [7:0] o_chop_disable_a,
   output wire [7:0] o_dither_disable_a_ext,
   output wire [7:0] o_special_mode_a,
   output wire [7:0] o_high_if_b_ctrl,
   output wire [7:0] o_chop_disable_b,
   output wire [7:0] o_dither_disable_b_ext,
   output wire [7:0] o_special_mode_b,
   output wire [7:0] o_high_if_common_ctrl,
   output wire [7:0] o_clock_filter_sync_ctrl
);

   // ------------------------------------------------------------
   // Address decode and field masks
   // ------------------------------------------------------------

   // Returns {hit, slot}; unmapped addresses give hit low
   function [5:0] reg_slot;
      input [13:0] adr;
      begin
         case (adr)
            `DITHER_DISABLE_CTRL_ADR:     reg_slot = {1'b1, 5'd0};
            `LANE_BIT_ORDER_CTRL_ADR:     reg_slot = {1'b1, 5'd1};
            `LANE_SWAP_CTRL_ADR:          reg_slot = {1'b1, 5'd2};
            `LANE_COUNT_SELECT_ADR:       reg_slot = {1'b1, 5'd3};
            `SOFT_RESET_TEST_ENABLE_ADR:  reg_slot = {1'b1, 5'd4};
            `OVERRANGE_ON_LSB_CTRL_ADR:   reg_slot = {1'b1, 5'd5};
            `OUTPUT_FORMAT_CTRL_ADR:      reg_slot = {1'b1, 5'd6};
            `CHAN_A_TEST_PATTERN_SEL_ADR: reg_slot = {1'b1, 5'd7};
            `CHAN_B_TEST_PATTERN_SEL_ADR: reg_slot = {1'b1, 5'd8};
            `CUSTOM_PATTERN_HIGH_ADR:     reg_slot = {1'b1, 5'd9};
            `CUSTOM_PATTERN_LOW_ADR:      reg_slot = {1'b1, 5'd10};
            `LOW_SPEED_CTRL_ADR:          reg_slot = {1'b1, 5'd11};
            `POWER_DOWN_CTRL_ADR:         reg_slot = {1'b1, 5'd12};
            `OUTPUT_SWING_CTRL_ADR:       reg_slot = {1'b1, 5'd13};
            `CLOCK_DIVIDER_CTRL_ADR:      reg_slot = {1'b1, 5'd14};
            `HIGH_IF_A_CTRL_ADR:          reg_slot = {1'b1, 5'd15};
            `CHOP_DISABLE_A_ADR:          reg_slot = {1'b1, 5'd16};
            `DITHER_DISABLE_A_EXT_ADR:    reg_slot = {1'b1, 5'd17};
            `SPECIAL_MODE_A_ADR:          reg_slot = {1'b1, 5'd18};
            `HIGH_IF_B_CTRL_ADR:          reg_slot = {1'b1, 5'd19};
            `CHOP_DISABLE_B_ADR:          reg_slot = {1'b1, 5'd20};
            `DITHER_DISABLE_B_EXT_ADR:    reg_slot = {1'b1, 5'd21};
            `SPECIAL_MODE_B_ADR:          reg_slot = {1'b1, 5'd22};
            `HIGH_IF_COMMON_CTRL_ADR:     reg_slot = {1'b1, 5'd23};
            `CLOCK_FILTER_SYNC_CTRL_ADR:  reg_slot = {1'b1, 5'd24};
            default:                      reg_slot = {1'b0, 5'd0};
         endcase
      end
   endfunction

   // Must-write-zero bits are not stored, so they read back as zero
   function [7:0] field_mask;
      input [4:0] idx;
      begin
         case (idx)
            5'd0:    field_mask = 8'h3c;
            5'd1:    field_mask = 8'h01;
            5'd2:    field_mask = 8'h01;
            5'd3:    field_mask = 8'h01;
            // Reset bit is an action, never stored
            5'd4:    field_mask = 8'h02;
            5'd5:    field_mask = 8'h01;
            5'd6:    field_mask = 8'h03;
            5'd7:    field_mask = 8'h0f;
            5'd8:    field_mask = 8'he0;
            5'd9:    field_mask = 8'hff;
            5'd10:   field_mask = 8'hfc;
            5'd11:   field_mask = 8'h03;
            5'd12:   field_mask = 8'h6d;
            5'd13:   field_mask = 8'hff;
            5'd14:   field_mask = 8'hc0;
            5'd15:   field_mask = 8'h02;
            5'd16:   field_mask = 8'h02;
            5'd17:   field_mask = 8'h28;
            5'd18:   field_mask = 8'h08;
            5'd19:   field_mask = 8'h02;
            5'd20:   field_mask = 8'h02;
            5'd21:   field_mask = 8'h28;
            5'd22:   field_mask = 8'h08;
            5'd23:   field_mask = 8'hc0;
            5'd24:   field_mask = 8'h81;
            default: field_mask = 8'h00;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   wire [3:0] pins_s;
   wire       sclk_s;
   wire       csn_s;
   wire       sdi_s;
   wire       hwrst_s;

   // Chip select resets deasserted so no false frame at start
   cfg_sync2 #(
      .WIDTH     (4),
      .RESET_VAL (4'h4)
   ) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_async   ({i_hw_reset, i_chip_select_n, i_serial_data_in, i_sclk}),
      .o_sync    (pins_s)
   );

   assign sclk_s  = pins_s[0];
   assign sdi_s   = pins_s[1];
   assign csn_s   = pins_s[2];
   assign hwrst_s = pins_s[3];

   // ------------------------------------------------------------
   // Serial clock edges
   // ------------------------------------------------------------
   reg  sclk_d_ff;
   wire sel;
   wire sclk_rise;
   wire sclk_fall;

   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sclk_d_ff <= 1'b0;
      end else begin
         sclk_d_ff <= sclk_s;
      end
   end

   assign sel       = ~csn_s;
   assign sclk_rise = sclk_s & ~sclk_d_ff;
   assign sclk_fall = ~sclk_s & sclk_d_ff;

   // ------------------------------------------------------------
   // Word assembly
   // ------------------------------------------------------------
   reg  [4:0]  bit_cnt_ff;
   reg  [22:0] shift_ff;
   reg         lock_ff;
   reg         rd_word_ff;
   reg  [4:0]  rd_idx_ff;
   reg         rd_hit_ff;
   reg         load_pend_ff;
   reg         wr_en_ff;
   reg  [4:0]  wr_idx_ff;
   reg  [7:0]  wr_data_ff;
   reg         soft_clr_ff;
   reg  [7:0]  rd_shift_ff;
   reg         sdo_ff;
   reg         sdo_en_ff;

   wire [23:0] word;
   wire        last_bit;
   wire        addr_done;
   wire [5:0]  wr_dec;
   wire [5:0]  rd_dec;
   wire [7:0]  rd_data;
   wire        bank_clear;
   wire [NREG*8-1:0] image;

   assign word      = {shift_ff, sdi_s};
   assign last_bit  = (bit_cnt_ff == 5'd23);
   assign addr_done = (bit_cnt_ff == 5'd15);
   assign wr_dec    = reg_slot(word[21:8]);
   assign rd_dec    = reg_slot({shift_ff[12:0], sdi_s});

   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         bit_cnt_ff <= 5'd0;
         shift_ff   <= 23'd0;
      end else if (!sel) begin
         bit_cnt_ff <= 5'd0;
         shift_ff   <= 23'd0;
      end else if (sclk_rise) begin
         shift_ff   <= word[22:0];
         bit_cnt_ff <= last_bit ? 5'd0 : bit_cnt_ff + 5'd1;
      end
   end

   // ------------------------------------------------------------
   // Read/write lock and register writes
   // ------------------------------------------------------------
   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         lock_ff      <= 1'b0;
         rd_word_ff   <= 1'b0;
         rd_idx_ff    <= 5'd0;
         rd_hit_ff    <= 1'b0;
      end else if (hwrst_s) begin
         lock_ff      <= 1'b0;
         rd_word_ff   <= 1'b0;
      end else if (sel && sclk_rise && addr_done) begin
         lock_ff      <= shift_ff[14];
         rd_word_ff   <= shift_ff[14];
         rd_idx_ff    <= rd_dec[4:0];
         rd_hit_ff    <= rd_dec[5];
      end else if (!sel) begin
         rd_word_ff   <= 1'b0;
      end
   end

   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_en_ff    <= 1'b0;
         wr_idx_ff   <= 5'd0;
         wr_data_ff  <= 8'h00;
         soft_clr_ff <= 1'b0;
      end else begin
         wr_en_ff    <= 1'b0;
         soft_clr_ff <= 1'b0;
         if (sel && sclk_rise && last_bit && !lock_ff && wr_dec[5]) begin
            wr_en_ff   <= 1'b1;
            wr_idx_ff  <= wr_dec[4:0];
            wr_data_ff <= word[7:0] & field_mask(wr_dec[4:0]);
            soft_clr_ff <= (wr_dec[4:0] == `SOFT_RESET_IDX) &&
                           word[`SOFT_RESET_BIT];
         end
      end
   end

   assign bank_clear = soft_clr_ff | hwrst_s;

   cfg_reg_bank #(
      .WIDTH (8),
      .DEPTH (NREG),
      .AW    (5)
   ) u_bank (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_clear   (bank_clear),
      .i_wr_en   (wr_en_ff),
      .i_wr_idx  (wr_idx_ff),
      .i_wr_data (wr_data_ff),
      .i_rd_idx  (rd_idx_ff),
      .o_rd_data (rd_data),
      .o_image   (image)
   );

   // ------------------------------------------------------------
   // Readback shifter
   // ------------------------------------------------------------
   // Bank read data settles long before the next serial clock fall
   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         load_pend_ff <= 1'b0;
         rd_shift_ff  <= 8'h00;
         sdo_ff       <= 1'b0;
         sdo_en_ff    <= 1'b0;
      end else if (!sel || hwrst_s) begin
         load_pend_ff <= 1'b0;
         sdo_en_ff    <= 1'b0;
         sdo_ff       <= 1'b0;
      end else if (sclk_rise) begin
         load_pend_ff <= addr_done & shift_ff[14];
         if (last_bit) begin
            sdo_en_ff <= 1'b0;
         end
      end else if (sclk_fall && load_pend_ff) begin
         load_pend_ff <= 1'b0;
         rd_shift_ff  <= rd_hit_ff ? {rd_data[6:0], 1'b0} : 8'h00;
         sdo_ff       <= rd_hit_ff & rd_data[7];
         sdo_en_ff    <= rd_word_ff;
      end else if (sclk_fall && sdo_en_ff) begin
         sdo_ff       <= rd_shift_ff[7];
         rd_shift_ff  <= {rd_shift_ff[6:0], 1'b0};
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------

   assign o_serial_data_out         = sdo_ff;
   assign o_serial_data_out_en      = sdo_en_ff;
   assign o_write_locked            = lock_ff;
   assign o_dither_disable_ctrl     = image[0*8 +: 8];
   assign o_lane_bit_order_ctrl     = image[1*8 +: 8];
   assign o_lane_swap_ctrl          = image[2*8 +: 8];
   assign o_lane_count_select       = image[3*8 +: 8];
   assign o_soft_reset_test_enable  = image[4*8 +: 8];
   assign o_overrange_on_lsb_ctrl   = image[5*8 +: 8];
   assign o_output_format_ctrl      = image[6*8 +: 8];
   assign o_chan_a_test_pattern_sel = image[7*8 +: 8];
   assign o_chan_b_test_pattern_sel = image[8*8 +: 8];
   assign o_custom_pattern_high     = image[9*8 +: 8];
   assign o_custom_pattern_low      = image[10*8 +: 8];
   assign o_low_speed_ctrl          = image[11*8 +: 8];
   assign o_power_down_ctrl         = image[12*8 +: 8];
   assign o_output_swing_ctrl       = image[13*8 +: 8];
   assign o_clock_divider_ctrl      = image[14*8 +: 8];
   assign o_high_if_a_ctrl          = image[15*8 +: 8];
   assign o_chop_disable_a          = image[16*8 +: 8];
   assign o_dither_disable_a_ext    = image[17*8 +: 8];
   assign o_special_mode_a          = image[18*8 +: 8];
   assign o_high_if_b_ctrl          = image[19*8 +: 8];
   assign o_chop_disable_b          = image[20*8 +: 8];
   assign o_dither_disable_b_ext    = image[21*8 +: 8];
   assign o_special_mode_b          = image[22*8 +: 8];
   assign o_high_if_common_ctrl     = image[23*8 +: 8];
   assign o_clock_filter_sync_ctrl  = image[24*8 +: 8];

endmodule // adc_serial_config_port

// >>> rtl/adc_serial_config_port_regs.vh
`ifndef ADC_SERIAL_CONFIG_PORT_REGS_VH
`define ADC_SERIAL_CONFIG_PORT_REGS_VH

`define WORD_BITS       24
`define ADDR_BITS       16
`define REG_COUNT       25
`define SOFT_RESET_BIT  0
`define REG_RESET_VAL   8'h00

`define DITHER_DISABLE_CTRL_ADR     14'h0001
`define LANE_BIT_ORDER_CTRL_ADR     14'h0003
`define LANE_SWAP_CTRL_ADR          14'h0004
`define LANE_COUNT_SELECT_ADR       14'h0005
`define SOFT_RESET_TEST_ENABLE_ADR  14'h0006
`define OVERRANGE_ON_LSB_CTRL_ADR   14'h0007
`define OUTPUT_FORMAT_CTRL_ADR      14'h0009
`define CHAN_A_TEST_PATTERN_SEL_ADR 14'h000a
`define CHAN_B_TEST_PATTERN_SEL_ADR 14'h000b
`define CUSTOM_PATTERN_HIGH_ADR     14'h000e
`define CUSTOM_PATTERN_LOW_ADR      14'h000f
`define LOW_SPEED_CTRL_ADR          14'h0013
`define POWER_DOWN_CTRL_ADR         14'h0015
`define OUTPUT_SWING_CTRL_ADR       14'h0025
`define CLOCK_DIVIDER_CTRL_ADR      14'h0027
`define HIGH_IF_A_CTRL_ADR          14'h041d
`define CHOP_DISABLE_A_ADR          14'h0422
`define DITHER_DISABLE_A_EXT_ADR    14'h0434
`define SPECIAL_MODE_A_ADR          14'h0439
`define HIGH_IF_B_CTRL_ADR          14'h051d
`define CHOP_DISABLE_B_ADR          14'h0522
`define DITHER_DISABLE_B_EXT_ADR    14'h0534
`define SPECIAL_MODE_B_ADR          14'h0539
`define HIGH_IF_COMMON_CTRL_ADR     14'h0608
`define CLOCK_FILTER_SYNC_CTRL_ADR  14'h070a

`define SOFT_RESET_IDX              5'd4

`endif

// >>> rtl/cfg_sync2.v
`timescale 1ns/1ps
module cfg_sync2 #(
   parameter WIDTH     = 1,
   parameter RESET_VAL = 0
) (
   input  wire             i_sys_clk,
   input  wire             i_rstn,
   input  wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);
   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] sync_ff;

   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_ff <= RESET_VAL[WIDTH-1:0];
         sync_ff <= RESET_VAL[WIDTH-1:0];
      end else begin
         meta_ff <= i_async;
         sync_ff <= meta_ff;
      end
   end

   assign o_sync = sync_ff;
endmodule // cfg_sync2

// >>> rtl/cfg_reg_bank.v
`timescale 1ns/1ps
`include "adc_serial_config_port_regs.vh"
module cfg_reg_bank #(
   parameter WIDTH = 8,
   parameter DEPTH = `REG_COUNT,
   parameter AW    = 5
) (
   input  wire                   i_sys_clk,
   input  wire                   i_rstn,
   input  wire                   i_clear,
   input  wire                   i_wr_en,
   input  wire [AW-1:0]          i_wr_idx,
   input  wire [WIDTH-1:0]       i_wr_data,
   input  wire [AW-1:0]          i_rd_idx,
   output wire [WIDTH-1:0]       o_rd_data,
   output wire [DEPTH*WIDTH-1:0] o_image
);
   reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
   reg [WIDTH-1:0] rd_data_ff;
   integer         k;

   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (k = 0; k < DEPTH; k = k + 1) begin
            mem_ff[k] <= `REG_RESET_VAL;
         end
         rd_data_ff <= `REG_RESET_VAL;
      end else begin
         // Clear wins over a write in the same cycle
         if (i_clear) begin
            for (k = 0; k < DEPTH; k = k + 1) begin
               mem_ff[k] <= `REG_RESET_VAL;
            end
         end else if (i_wr_en) begin
            mem_ff[i_wr_idx] <= i_wr_data;
         end
         rd_data_ff <= mem_ff[i_rd_idx];
      end
   end

   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : g_img
         assign o_image[g*WIDTH +: WIDTH] = mem_ff[g];
      end
   endgenerate

   assign o_rd_data = rd_data_ff;
endmodule // cfg_reg_bank

// >>> test/adc_serial_config_port_assertions.sv
`timescale 1ns/1ps
module adc_serial_config_port_chk (
   input wire logic       i_sys_clk,
   input wire logic       i_rstn,
   input wire logic       i_sclk,
   input wire logic       i_chip_select_n,
   input wire logic       i_hw_reset,
   input wire logic       o_serial_data_out,
   input wire logic       o_serial_data_out_en,
   input wire logic       o_write_locked,
   input wire logic [7:0] o_soft_reset_test_enable,
   input wire logic [7:0] o_custom_pattern_high,
   input wire logic [7:0] o_clock_filter_sync_ctrl
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn);

   wire [23:0] regs = {o_custom_pattern_high, o_soft_reset_test_enable, o_clock_filter_sync_ctrl};

   AST_CS_OFF: assert property (
      $rose(i_chip_select_n) |-> ##[1:6] !o_serial_data_out_en)
      else $error("data out still driven after deselect");
   AST_EN_CAUSE: assert property (
      o_serial_data_out_en |-> $past(i_chip_select_n, 5) == 1'b0)
      else $error("data out driven without selection");
   AST_EN_LOCK: assert property (
      $rose(o_serial_data_out_en) |-> o_write_locked && !i_sclk)
      else $error("readback started outside a read word");
   AST_OUT_ON_FALL: assert property (
      o_serial_data_out_en && $past(o_serial_data_out_en) && $changed(o_serial_data_out)
      |-> !i_sclk && !$past(i_sclk, 2))
      else $error("data out changed while serial clock high");
   AST_EN_DROP: assert property (
      $fell(o_serial_data_out_en) && !i_chip_select_n |-> i_sclk)
      else $error("readback ended away from word end");
   AST_LOCK_HOLD: assert property (
      @(posedge i_sys_clk) disable iff (!i_rstn || i_hw_reset)
      o_write_locked && $past(o_write_locked) |-> $stable(regs))
      else $error("register changed while writes locked");
   AST_REG_ON_RISE: assert property (
      @(posedge i_sys_clk) disable iff (!i_rstn || i_hw_reset)
      $changed(regs) |-> i_sclk && $past(i_sclk, 2))
      else $error("register changed away from serial clock rise");
   AST_HWRST: assert property (
      i_hw_reset [*5] |-> !o_write_locked && !o_serial_data_out_en && regs == 24'h00_0000)
      else $error("reset pin did not clear state");
   AST_SOFT_SELF: assert property (
      o_soft_reset_test_enable[0] == 1'b0)
      else $error("soft reset bit stored");
   AST_MASK: assert property (
      (o_clock_filter_sync_ctrl & 8'h7e) == 8'h00)
      else $error("zero field bits set");
endmodule // adc_serial_config_port_chk

bind adc_serial_config_port adc_serial_config_port_chk chk (
   .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_sclk(i_sclk),
   .i_chip_select_n(i_chip_select_n), .i_hw_reset(i_hw_reset),
   .o_serial_data_out(o_serial_data_out), .o_serial_data_out_en(o_serial_data_out_en),
   .o_write_locked(o_write_locked), .o_soft_reset_test_enable(o_soft_reset_test_enable),
   .o_custom_pattern_high(o_custom_pattern_high),
   .o_clock_filter_sync_ctrl(o_clock_filter_sync_ctrl));

// >>> test/cfg_ctrl_model.sv
`timescale 1ns/1ps
module cfg_ctrl_model #(
   parameter POWER_ON_NS = 1000000
) (
   input  wire i_sdo,
   input  wire i_sdo_en,
   output reg  o_sclk,
   output reg  o_cs_n,
   output reg  o_sdi,
   output reg  o_hw_reset
);
   // Released data line floats
   wire sdo_w = i_sdo_en ? i_sdo : 1'bz;

   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_sdi = 1'b0;
      o_hw_reset = 1'b0;
   end

   function [23:0] wr_word(input [13:0] a, input [7:0] d);
      wr_word = {2'b01, a, d};
   endfunction

   function [23:0] rd_word(input [13:0] a);
      rd_word = {2'b11, a, 8'h00};
   endfunction

   task pwr_reset;
      begin
         #(POWER_ON_NS);
         o_hw_reset = 1'b1;
         #40;
         o_hw_reset = 1'b0;
         #120;
      end
   endtask

   task frame(input [47:0] bits, input integer n, output [7:0] rd);
      integer i;
      begin
         rd = 8'h00;
         o_cs_n = 1'b0;
         // Quarter offset keeps pin edges off the sampling clock edge
         #62.75;
         for (i = 47; i > 47 - n; i = i - 1) begin
            o_sdi = bits[i];
            #62.5;
            o_sclk = 1'b1;
            rd = {rd[6:0], sdo_w};
            #62.5;
            o_sclk = 1'b0;
         end
         #62.5;
         o_cs_n = 1'b1;
         // No pull on the line: leave a changed value
         o_sdi = ~o_sdi;
         #250;
      end
   endtask
endmodule // cfg_ctrl_model

// >>> test/adc_serial_config_port_tb.sv
`timescale 1ns/1ps
module adc_serial_config_port_tb;
   reg        clk;
   reg        rstn;
   reg  [7:0] rd;
   wire       sclk, cs_n, sdi, hwr, sdo, sdo_en, lock;
   wire [7:0] r06, r0e, r70a;
   wire [63:0] rp;
   integer    error_cnt = 0;
   integer    checked = 0;
   integer    cyc = 0;
   integer    i;
   localparam [175:0] TBL = {14'h0001, 8'h3c, 14'h000e, 8'hff, 14'h000f, 8'hfc,
      14'h0015, 8'h6d, 14'h070a, 8'h81, 14'h0539, 8'h08, 14'h000b, 8'he0, 14'h0027, 8'hc0};

   cfg_ctrl_model #(.POWER_ON_NS(2000)) ctl (.i_sdo(sdo), .i_sdo_en(sdo_en), .o_sclk(sclk),
      .o_cs_n(cs_n), .o_sdi(sdi), .o_hw_reset(hwr));

   adc_serial_config_port uut (.i_sys_clk(clk), .i_rstn(rstn), .i_sclk(sclk),
      .i_chip_select_n(cs_n), .i_serial_data_in(sdi), .i_hw_reset(hwr),
      .o_serial_data_out(sdo), .o_serial_data_out_en(sdo_en), .o_write_locked(lock),
      .o_dither_disable_ctrl(rp[63:56]), .o_lane_bit_order_ctrl(), .o_lane_swap_ctrl(),
      .o_lane_count_select(), .o_soft_reset_test_enable(r06), .o_overrange_on_lsb_ctrl(),
      .o_output_format_ctrl(), .o_chan_a_test_pattern_sel(),
      .o_chan_b_test_pattern_sel(rp[15:8]),
      .o_custom_pattern_high(r0e), .o_custom_pattern_low(rp[47:40]), .o_low_speed_ctrl(),
      .o_power_down_ctrl(rp[39:32]), .o_output_swing_ctrl(), .o_clock_divider_ctrl(rp[7:0]),
      .o_high_if_a_ctrl(), .o_chop_disable_a(), .o_dither_disable_a_ext(),
      .o_special_mode_a(), .o_high_if_b_ctrl(), .o_chop_disable_b(),
      .o_dither_disable_b_ext(), .o_special_mode_b(rp[23:16]), .o_high_if_common_ctrl(),
      .o_clock_filter_sync_ctrl(r70a));

   assign rp[55:48] = r0e;
   assign rp[31:24] = r70a;

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task check(input [7:0] seen, input [7:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   task settle;
      begin
         repeat (12) @(posedge clk);
         #1;
      end
   endtask

   task wr(input [13:0] a, input [7:0] d);
      begin
         ctl.frame({ctl.wr_word(a, d), 24'h00_0000}, 24, rd);
         settle;
      end
   endtask

   task rdb(input [13:0] a, output [7:0] v);
      begin
         ctl.frame({ctl.rd_word(a), 24'h00_0000}, 24, v);
         settle;
      end
   endtask

   task results;
      begin
         $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
         if (error_cnt == 0 && checked > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_map;
      reg [7:0] v;
      begin
         for (i = 0; i < 8; i = i + 1)
            wr(TBL[175 - 22 * i -: 14], 8'hff);
         for (i = 0; i < 8; i = i + 1) begin
            rdb(TBL[175 - 22 * i -: 14], v);
            check(v, TBL[161 - 22 * i -: 8]);
            check(rp[63 - 8 * i -: 8], TBL[161 - 22 * i -: 8]);
         end
         rdb(14'h0002, v);
         check(v, 8'h00);
         check({7'h00, sdo_en}, 8'h00);
         $display("map test done");
      end
   endtask

   task t_multi;
      begin
         ctl.frame({ctl.wr_word(14'h000e, 8'h5a), ctl.wr_word(14'h000f, 8'ha4)}, 48, rd);
         settle;
         check(r0e, 8'h5a);
         // Last data bit withheld
         ctl.frame({ctl.wr_word(14'h000e, 8'h11), 24'h00_0000}, 23, rd);
         settle;
         check(r0e, 8'h5a);
         $display("multi word test done");
      end
   endtask

   task t_lock;
      reg [7:0] v;
      begin
         rdb(14'h000f, v);
         check(v, 8'ha4);
         check({7'h00, lock}, 8'h01);
         // Read word carrying live data bits must not write
         ctl.frame({2'b11, 14'h000e, 8'hc3, 24'h00_0000}, 24, v);
         settle;
         check(v, 8'h5a);
         check(r0e, 8'h5a);
         wr(14'h000e, 8'h33);
         check({7'h00, lock}, 8'h00);
         check(r0e, 8'h33);
         $display("lock test done");
      end
   endtask

   task t_soft;
      begin
         wr(14'h0006, 8'h02);
         check(r06, 8'h02);
         wr(14'h0006, 8'h03);
         check(r06, 8'h00);
         check(r0e, 8'h00);
         check(r70a, 8'h00);
         $display("soft reset test done");
      end
   endtask

   task t_hw;
      reg [7:0] v;
      begin
         wr(14'h070a, 8'h80);
         check(r70a, 8'h80);
         rdb(14'h070a, v);
         check(v, 8'h80);
         ctl.pwr_reset;
         #1;
         check({7'h00, lock}, 8'h00);
         check(r70a, 8'h00);
         $display("pin reset test done");
      end
   endtask

   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         error_cnt = error_cnt + 1;
         results;
      end
   end

   initial begin
      rstn = 1'b0;
      repeat (3) @(posedge clk);
      #1 rstn = 1'b1;
      settle;
      check({lock, sdo_en, 6'h00}, 8'h00);
      ctl.pwr_reset;
      check(r0e, 8'h00);
      t_map;
      t_multi;
      t_lock;
      t_soft;
      t_hw;
      results;
   end
endmodule // adc_serial_config_port_tb
